/* wdt_pkg.sv */
// Function
// - timeout count is counter bits 5:0, each adding one 16384-cycle decrement period
// - first decrement after a write comes within the free-running prescaler phase
// - prescaler phase constants follow the time-base selection from the clock controller
// - above a quarter of high constant, floor(4*count/high) periods shortened to (192+low)*64
// - halt, interrupt off, halt-reset clear: decrement once, stop, no reset possible
// - external interrupt ends that halt; counting resumes after 256 or 4096 clocks
// - reset ending halt disables watchdog unless hardware watchdog option
// - halt, interrupt off, halt-reset set: reset request instead of halt
// - halt with interrupt enabled: active halt, no reset, counter stops
// - oscillator or external interrupt leaves active halt; counting resumes at once
// - reset leaving active halt: counting resumes after 256 or 4096 clocks
// - hardware watchdog option keeps watchdog active; activation bit ignored
// - active watchdog requests reset when counter rolls from 40h to 3Fh
// - counter decrements every period even while watchdog disabled
// - watchdog disabled after reset; once activated only reset disables it
// - writing activation set with counter top bit clear requests reset at once
package wdt_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [9:0] CTRL_INDEX = 10'h02a;
   localparam logic [11:0] CTRL_ADDR = {CTRL_INDEX, 2'h0};
   localparam int ACT_BIT = 7;
   localparam int TOP_BIT = 6;
   localparam logic [6:0] COUNT_RESET = 7'h7f;
   localparam logic [6:0] ROLL_FROM = 7'h40;
   // ---------------------------------------------------------------
   // timing, in oscillator cycles
   // ---------------------------------------------------------------
   localparam int unsigned DECR_PERIOD_CYC = 16384;
   localparam logic [7:0] SHORT_BASE = 8'hc0;
   localparam int SHORT_SHIFT = 6;
   localparam logic [5:0] PHASE_STEP = 6'h04;
   localparam logic [12:0] WAKE_SHORT = 13'h0100;
   localparam logic [12:0] WAKE_LONG = 13'h1000;
   // ---------------------------------------------------------------
   // phase constants per time-base selection
   // ---------------------------------------------------------------
   localparam logic [5:0] HIGH_SEL0 = 6'h04;
   localparam logic [5:0] LOW_SEL0 = 6'h3b;
   localparam logic [5:0] HIGH_SEL1 = 6'h08;
   localparam logic [5:0] LOW_SEL1 = 6'h35;
   localparam logic [5:0] HIGH_SEL2 = 6'h14;
   localparam logic [5:0] LOW_SEL2 = 6'h23;
   localparam logic [5:0] HIGH_SEL3 = 6'h31;
   localparam logic [5:0] LOW_SEL3 = 6'h36;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic haltResetOption;
      logic hwWatchdogOption;
      logic longWakeDelay;
   } wdt_opt_t;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_HALT_ONCE = 3'b001,
      ST_HALTED = 3'b010,
      ST_ACTIVE_HALT = 3'b011,
      ST_WAKE_DELAY = 3'b100
   } wdt_state_t;
endpackage

/* wdt_core.sv */
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module wdt_core #(
   parameter int unsigned DECR_PERIOD = wdt_pkg::DECR_PERIOD_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] timebaseSelect,
   input wire logic rtcInterruptEnable,
   input wire logic haltReq,
   input wire logic extIntWake,
   input wire logic oscIntWake,
   input wire wdt_pkg::wdt_opt_t optIn,
   output logic resetReq,
   output logic watchdogActive
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   wdt_pkg::wdt_state_t state_q, state_d;
   wdt_pkg::wdt_opt_t opt_q;
   logic optSampled_q;
   logic [6:0] cnt_q, cnt_d;
   logic en_q;
   logic [13:0] presc_q;
   logic [5:0] phase_q, phase_d;
   logic shortNext_q, shortNext_d;
   logic [12:0] wakeCnt_q, wakeCnt_d;
   logic pready_q, pslverr_q, rst_q, active_q;
   logic [31:0] prdata_q;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire logic access = psel && penable;
   wire logic apbDone = access && pready_q;
   wire logic addrHit = (paddr == wdt_pkg::CTRL_ADDR);
   wire logic ctrlWrite = apbDone && pwrite && addrHit;
   wire logic hwOpt = optSampled_q && opt_q.hwWatchdogOption;
   wire logic haltRstOpt = optSampled_q && opt_q.haltResetOption;
   wire logic wakeLong = optSampled_q ? opt_q.longWakeDelay : optIn.longWakeDelay;
   wire logic [12:0] wakeLen = wakeLong ? wdt_pkg::WAKE_LONG : wdt_pkg::WAKE_SHORT;
   wire logic effEn = en_q || hwOpt;

   // phase constants from the shared time-base selection
   // phase constant select
   wire logic [5:0] highC = (timebaseSelect == 2'h0) ? wdt_pkg::HIGH_SEL0 :
                            (timebaseSelect == 2'h1) ? wdt_pkg::HIGH_SEL1 :
                            (timebaseSelect == 2'h2) ? wdt_pkg::HIGH_SEL2 : wdt_pkg::HIGH_SEL3;
   wire logic [5:0] lowC = (timebaseSelect == 2'h0) ? wdt_pkg::LOW_SEL0 :
                           (timebaseSelect == 2'h1) ? wdt_pkg::LOW_SEL1 :
                           (timebaseSelect == 2'h2) ? wdt_pkg::LOW_SEL2 : wdt_pkg::LOW_SEL3;

   // period length: full, or shortened to (192+low)*64
   // shortened period length
   wire logic [7:0] shortSum = wdt_pkg::SHORT_BASE + {2'h0, lowC};
   wire logic [14:0] shortLen = {1'b0, shortSum, 6'h00};
   wire logic [14:0] fullLen = 15'(DECR_PERIOD);
   wire logic [14:0] periodLen = shortNext_q ? shortLen : fullLen;
   wire logic tick = ({1'b0, presc_q} == (periodLen - 15'h0001));

   // the counter decrements only while running or finishing the halt decrement
   wire logic countEn = (state_q == wdt_pkg::ST_RUN) || (state_q == wdt_pkg::ST_HALT_ONCE);

   // reset causes
   // roll from 40h
   wire logic rollReset = effEn && tick && countEn && (state_q == wdt_pkg::ST_RUN)
                          && (cnt_q == wdt_pkg::ROLL_FROM);
   // software triggered reset
   // the activation bit is sticky, so an active watchdog resets on top bit clear alone
   wire logic swReset = ctrlWrite && !pwdata[wdt_pkg::TOP_BIT]
                        && (pwdata[wdt_pkg::ACT_BIT] || effEn);
   wire logic haltReset = (state_q == wdt_pkg::ST_RUN) && haltReq && !rtcInterruptEnable
                          && haltRstOpt;
   wire logic anyReset = rollReset || swReset || haltReset;

   // ---------------------------------------------------------------
   // prescaler phase tracking
   // ---------------------------------------------------------------
   // count shortened periods
   always_comb begin
      logic [5:0] acc;
      acc = phase_q + wdt_pkg::PHASE_STEP;
      phase_d = phase_q;
      shortNext_d = shortNext_q;
      if (tick) begin
         if (acc >= highC) begin
            phase_d = acc - highC;
            shortNext_d = 1'b1;
         end else begin
            phase_d = acc;
            shortNext_d = 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // counter next value
   // ---------------------------------------------------------------
   // decrements whatever the enable; a write has priority and
   // leaves the prescaler alone, so the first decrement lands early
   // write keeps prescaler phase
   always_comb begin
      cnt_d = cnt_q;
      if (ctrlWrite) begin
         cnt_d = pwdata[6:0];
      end else if (tick && countEn) begin
         cnt_d = cnt_q - 7'h01;
      end
   end

   // ---------------------------------------------------------------
   // halt mode sequencing
   // ---------------------------------------------------------------
   // slow and wait have no input here: they cannot touch the counter
   // no slow or wait effect
   always_comb begin
      state_d = state_q;
      wakeCnt_d = wakeCnt_q;
      unique case (state_q)
         wdt_pkg::ST_RUN: begin
            if (haltReq && rtcInterruptEnable) begin
               state_d = wdt_pkg::ST_ACTIVE_HALT;
            end else if (haltReq && !haltRstOpt) begin
               state_d = wdt_pkg::ST_HALT_ONCE;
            end
         end
         wdt_pkg::ST_HALT_ONCE: begin
            if (extIntWake) begin
               state_d = wdt_pkg::ST_WAKE_DELAY;
               wakeCnt_d = wakeLen;
            end else if (tick) begin
               state_d = wdt_pkg::ST_HALTED;
            end
         end
         wdt_pkg::ST_HALTED: begin
            if (extIntWake) begin
               state_d = wdt_pkg::ST_WAKE_DELAY;
               wakeCnt_d = wakeLen;
            end
         end
         wdt_pkg::ST_ACTIVE_HALT: begin
            if (extIntWake || oscIntWake) begin
               state_d = wdt_pkg::ST_RUN;
            end
         end
         wdt_pkg::ST_WAKE_DELAY: begin
            if (!optSampled_q) begin
               wakeCnt_d = wakeLen;
            end else if (wakeCnt_q <= 13'h0001) begin
               state_d = wdt_pkg::ST_RUN;
            end else begin
               wakeCnt_d = wakeCnt_q - 13'h0001;
            end
         end
         default: begin
            state_d = wdt_pkg::ST_RUN;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // option straps, caught once after reset release
   // ---------------------------------------------------------------
   // sample options
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         opt_q <= '0;
         optSampled_q <= 1'b0;
      end else if (ce && !optSampled_q) begin
         opt_q <= optIn;
         optSampled_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // watchdog registers
   // ---------------------------------------------------------------
   // every reset restarts through the wake delay and clears the enable
   // disabled after reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= wdt_pkg::ST_WAKE_DELAY;
         wakeCnt_q <= 13'h0000;
         cnt_q <= wdt_pkg::COUNT_RESET;
         en_q <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
         wakeCnt_q <= wakeCnt_d;
         cnt_q <= cnt_d;
         en_q <= en_q || (ctrlWrite && pwdata[wdt_pkg::ACT_BIT]);
      end
   end

   // prescaler is shared with the time base, so it never restarts on a write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         presc_q <= 14'h0000;
         phase_q <= 6'h00;
         shortNext_q <= 1'b0;
      end else if (ce) begin
         presc_q <= tick ? 14'h0000 : presc_q + 14'h0001;
         phase_q <= phase_d;
         shortNext_q <= shortNext_d;
      end
   end

   // reset request and status outputs, all registered
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_q <= 1'b0;
         active_q <= 1'b0;
      end else if (ce) begin
         rst_q <= anyReset;
         active_q <= effEn;
      end
   end

   // ---------------------------------------------------------------
   // apb slave: one wait state, error on any other address
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (ce) begin
         pready_q <= access && !pready_q;
         pslverr_q <= access && !pready_q && !addrHit;
         if (access && !pready_q) begin
            prdata_q <= addrHit ? {24'h00_0000, effEn, cnt_q} : 32'h0000_0000;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign resetReq = rst_q;
   assign watchdogActive = active_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_roll_reset;
      ce && rollReset |=> resetReq;
   endproperty
   a_roll_reset: assert property (p_roll_reset) else $error("no reset on roll");

   property p_sw_reset;
      ce && ctrlWrite && pwdata[7] && !pwdata[6] |=> resetReq;
   endproperty
   a_sw_reset: assert property (p_sw_reset) else $error("no software reset");

   property p_halt_reset;
      ce && state_q == wdt_pkg::ST_RUN && haltReq && !rtcInterruptEnable && haltRstOpt
         |=> resetReq && state_q == wdt_pkg::ST_RUN;
   endproperty
   a_halt_reset: assert property (p_halt_reset) else $error("halt did not reset");

   property p_active_stop;
      state_q == wdt_pkg::ST_ACTIVE_HALT && !ctrlWrite |=> $stable(cnt_q);
   endproperty
   a_active_stop: assert property (p_active_stop) else $error("count moved in halt");

   property p_halted_quiet;
      state_q == wdt_pkg::ST_HALTED |-> !rollReset && !countEn;
   endproperty
   a_halted_quiet: assert property (p_halted_quiet) else $error("halted watchdog live");

   property p_wake_delay;
      ce && optSampled_q && state_q == wdt_pkg::ST_HALTED && extIntWake
         |=> state_q == wdt_pkg::ST_WAKE_DELAY && wakeCnt_q == wakeLen;
   endproperty
   a_wake_delay: assert property (p_wake_delay) else $error("wake delay wrong");

   property p_active_wake;
      ce && state_q == wdt_pkg::ST_ACTIVE_HALT && oscIntWake |=> state_q == wdt_pkg::ST_RUN;
   endproperty
   a_active_wake: assert property (p_active_wake) else $error("slow active wake");

   property p_enable_sticky;
      en_q |=> en_q;
   endproperty
   a_enable_sticky: assert property (p_enable_sticky) else $error("enable dropped");

   property p_hw_active;
      ce && hwOpt |=> watchdogActive;
   endproperty
   a_hw_active: assert property (p_hw_active) else $error("hw watchdog idle");

   property p_tick_step;
      ce && tick && countEn && !ctrlWrite |=> cnt_q == $past(cnt_q) - 7'h01;
   endproperty
   a_tick_step: assert property (p_tick_step) else $error("missed decrement");

   c_roll: cover property (ce && rollReset);
   c_sw: cover property (ce && swReset);
   c_active: cover property (state_q == wdt_pkg::ST_ACTIVE_HALT ##1 state_q == wdt_pkg::ST_RUN);
   c_halt: cover property (state_q == wdt_pkg::ST_HALTED ##1 state_q == wdt_pkg::ST_WAKE_DELAY);
endmodule // wdt_core

/* wdt_testbench.sv */
`timescale 1ns/1ps
module testbench;
   // ---------------------------------------------------------------
   // signals and bench state
   // ---------------------------------------------------------------
   typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} wdt_exp_t;
   localparam int PER = 64;
   localparam int WAKE = 256;
   localparam logic [11:0] CTRL = wdt_pkg::CTRL_ADDR;
   localparam logic [11:0] BAD_ADDR = 12'h0ac;
   logic clk, nrst, ce, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, lastRd, keep;
   logic [1:0] timebaseSelect;
   logic rtcInterruptEnable, haltReq, extIntWake, oscIntWake, resetReq, watchdogActive;
   wdt_pkg::wdt_opt_t optIn;
   int n_fail, n_tests;
   integer seed;
   logic [6:0] v;
   wdt_exp_t e;
   wdt_exp_t expQ[$];
   bit resetQ[$];

   wdt_core #(.DECR_PERIOD(PER)) DUT (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timebaseSelect(timebaseSelect),
      .rtcInterruptEnable(rtcInterruptEnable), .haltReq(haltReq), .extIntWake(extIntWake),
      .oscIntWake(oscIntWake), .optIn(optIn), .resetReq(resetReq),
      .watchdogActive(watchdogActive));

   // clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task chk(string name, logic [31:0] expv, logic [31:0] got);
      n_tests++;
      if (got !== expv) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, expv, got);
      end
   endtask

   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // one apb transfer; pready is sampled on the rising edge, read data taken at that edge
   task apb(logic wr, logic [11:0] a, logic [31:0] d, logic [31:0] ev, logic [31:0] m, logic er);
      int k;
      expQ.push_back('{ev, m, er});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      lastRd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) chk("pready timeout", 1, 0);
   endtask

   // one-cycle pulse: 0 halt, 1 external wake, 2 oscillator wake
   task pulse(int w);
      @(posedge clk);
      case (w)
         0: haltReq <= 1'b1;
         1: extIntWake <= 1'b1;
         default: oscIntWake <= 1'b1;
      endcase
      @(posedge clk);
      haltReq <= 1'b0;
      extIntWake <= 1'b0;
      oscIntWake <= 1'b0;
   endtask

   task doReset(logic [2:0] o, int settle);
      nrst <= 1'b0;
      optIn <= o;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (settle) @(posedge clk);
   endtask

   // bounded wait until every announced reset request has been seen
   task waitReset(int lim);
      int k;
      k = 0;
      while (resetQ.size() != 0 && k < lim) begin
         @(posedge clk);
         k++;
      end
      chk("pending reset requests", 0, resetQ.size());
   endtask

   // ---------------------------------------------------------------
   // observer: any reset pulse nobody announced is a mismatch
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (psel && penable && pready) begin
         e = expQ.pop_front();
         chk("prdata", e.data & e.mask, prdata & e.mask);
         chk("pslverr", {31'h0, e.err}, {31'h0, pslverr});
      end
      if (resetReq === 1'b1) begin
         if (resetQ.size() == 0) chk("unexpected reset request", 0, 1);
         else void'(resetQ.pop_front());
      end
   end

   // watchdog on the bench itself, well beyond the longest test path
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      $display("timeout");
      tally_and_finish();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      nrst = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; timebaseSelect = 2'b11; rtcInterruptEnable = 1'b0;
      haltReq = 1'b0; extIntWake = 1'b0; oscIntWake = 1'b0; optIn = '0;
      n_fail = 0; n_tests = 0; seed = 32'h6846;
      doReset(3'b000, 3);
      chk("watchdogActive", 0, watchdogActive);
      apb(0, CTRL, 0, 32'h7f, 32'hffffffff, 0);
      repeat (WAKE + 300) @(posedge clk);
      apb(0, CTRL, 0, 32'h40, 32'hc0, 0);
      chk("counter running", 1, lastRd[6:0] < 7'h7f);
      // clock enable low freezes counter and prescaler alike
      keep = lastRd;
      ce <= 1'b0;
      repeat (300) @(posedge clk);
      ce <= 1'b1;
      apb(0, CTRL, 0, 32'h40, 32'hc0, 0);
      chk("frozen count", 1, (keep[6:0] - lastRd[6:0]) <= 7'h02);
      $display("test reset and free run done");
      // refused address: a write that would fire a reset is ignored
      apb(1, BAD_ADDR, 32'h80, 0, 0, 1);
      apb(0, BAD_ADDR, 0, 0, 32'hffffffff, 1);
      for (int i = 0; i < 4; i++) begin
         v = {1'b1, 6'($random(seed)) | 6'h01};
         apb(1, CTRL, {25'h0, v}, 0, 0, 0);
         apb(0, CTRL, 0, 32'h40, 32'hffffffc0, 0);
         chk("loaded count", 1, (v - lastRd[6:0]) <= 7'h01);
      end
      $display("test refusal and load done");
      // activation sticks; software reset via top bit clear
      apb(1, CTRL, 32'hff, 0, 0, 0);
      apb(1, CTRL, 32'h7f, 0, 0, 0);
      apb(0, CTRL, 0, 32'h80, 32'h80, 0);
      chk("watchdogActive", 1, watchdogActive);
      resetQ.push_back(1'b1);
      apb(1, CTRL, 32'h3f, 0, 0, 0);
      waitReset(4);
      $display("test software reset done");
      doReset(3'b000, WAKE + 4);
      resetQ.push_back(1'b1);
      apb(1, CTRL, 32'hc1, 0, 0, 0);
      waitReset(40000);
      $display("test roll reset done");
      // halt-reset option: halt turns into a reset request
      doReset(3'b100, WAKE + 4);
      resetQ.push_back(1'b1);
      pulse(0);
      waitReset(3);
      // active halt freezes the counter, even with halt-reset option
      rtcInterruptEnable <= 1'b1;
      apb(1, CTRL, 32'hff, 0, 0, 0);
      pulse(0);
      apb(0, CTRL, 0, 32'h80, 32'h80, 0);
      keep = lastRd;
      repeat (400) @(posedge clk);
      apb(0, CTRL, 0, keep, 32'hff, 0);
      pulse(2);
      repeat (400) @(posedge clk);
      apb(0, CTRL, 0, 32'h80, 32'h80, 0);
      chk("counting after wake", 1, lastRd[6:0] < keep[6:0]);
      rtcInterruptEnable <= 1'b0;
      $display("test halt reset and active halt done");
      // plain halt: one decrement then stop; live option change is ignored
      doReset(3'b000, WAKE + 4);
      optIn <= 3'b100;
      apb(1, CTRL, 32'hc1, 0, 0, 0);
      pulse(0);
      repeat (17000) @(posedge clk);
      apb(0, CTRL, 0, 32'hc0, 32'hff, 0);
      pulse(1);
      repeat (WAKE - 60) @(posedge clk);
      apb(0, CTRL, 0, 32'hc0, 32'hff, 0);
      resetQ.push_back(1'b1);
      waitReset(40000);
      $display("test plain halt done");
      // hardware option: active without the activation bit
      doReset(3'b010, WAKE + 4);
      chk("watchdogActive", 1, watchdogActive);
      resetQ.push_back(1'b1);
      apb(1, CTRL, 32'h3f, 0, 0, 0);
      waitReset(4);
      $display("test hardware option done");
      tally_and_finish();
   end
endmodule // testbench
